// >>> design/nvbs_ctrl.sv
/*
 nvbs_ctrl: control register and cycle sequencing for byte accesses
 to the nonvolatile store.
 Assumes: core writes/reads the control register with one-cycle strobes;
 the cell array answers fetches with fetch_ack and fetch_byte.
*/
// What this block does
// - Control bits 7 to 4 read zero and ignore writes.
// - Bit 3 store permit, read/write, resets to zero.
// - Writing 1 to bit 2 starts storing held byte at held location.
// - Bit 2 clears itself when the store completes; reads 1 meanwhile.
// - Bit 2 reading 0 means no store is pending.
// - Store launch ignored unless permit was already set.
// - Fetches blocked while fetch permit bit 1 is zero; resets zero.
// - Bit 0 starts a fetch; clears once the byte lands in data.
// - Fetch launch ignored unless fetch permit was already set.
// - Each store end sets a done flag held until software clears it.
`timescale 1ns/1ps
module nvbs_ctrl
    import nvbs_pkg::*;
#(
    parameter logic [15:0] STORE_LEN = STORE_TICKS
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              srst,
    // control register access from the core
    input  wire logic              ctrl_wr,
    input  wire logic [CTRL_W-1:0] ctrl_wdata,
    output logic      [CTRL_W-1:0] nv_access_control,
    // held location and byte
    input  wire logic [LOC_W-1:0]  nv_location,
    input  wire logic [BYTE_W-1:0] nv_byte,
    input  wire logic              nv_byte_wr,
    output logic      [BYTE_W-1:0] nv_byte_q,
    // cell array side
    output logic                   cell_store,
    output logic                   cell_fetch,
    output logic      [LOC_W-1:0]  cell_loc,
    output logic      [BYTE_W-1:0] cell_wdata,
    input  wire logic              fetch_ack,
    input  wire logic [BYTE_W-1:0] fetch_byte,
    // completion flag
    input  wire logic              store_done_clr,
    output logic                   store_done
);
    nvbs_state_t state;
    logic        store_permit;
    logic        fetch_permit;
    logic        store_go;
    logic        fetch_go;
    logic        want_store;
    logic        want_fetch;

    nvbs_tick_if tif ();

    nvbs_store_timer #(
        .TICKS (STORE_LEN)
    ) u_timer (
        .clk  (clk),
        .srst (srst),
        .tif  (tif)
    );

    // permit must already be set before this write
    assign want_store = ctrl_wr && ctrl_wdata[BIT_STORE_GO]
                        && store_permit && state == NVBS_IDLE;
    assign want_fetch = ctrl_wr && ctrl_wdata[BIT_FETCH_GO]
                        && fetch_permit && state == NVBS_IDLE
                        && !want_store;
    assign tif.start  = want_store;

    always_ff @(posedge clk) begin
        if (srst) begin
            store_permit <= 1'b0;
            fetch_permit <= 1'b0;
        end else if (ctrl_wr) begin
            store_permit <= ctrl_wdata[BIT_STORE_PERM];
            fetch_permit <= ctrl_wdata[BIT_FETCH_PERM];
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state <= NVBS_IDLE;
        end else begin
            case (state)
                NVBS_IDLE: begin
                    if (want_store) begin
                        state <= NVBS_STORE;
                    end else if (want_fetch) begin
                        state <= NVBS_FETCH;
                    end
                end
                NVBS_STORE: begin
                    if (tif.done) begin
                        state <= NVBS_IDLE;
                    end
                end
                NVBS_FETCH: begin
                    if (fetch_ack) begin
                        state <= NVBS_IDLE;
                    end
                end
                default: begin
                    state <= NVBS_IDLE;
                end
            endcase
        end
    end

    assign store_go = (state == NVBS_STORE);
    assign fetch_go = (state == NVBS_FETCH);

    // launch strobes and latched operands toward the cells
    always_ff @(posedge clk) begin
        if (srst) begin
            cell_store <= 1'b0;
            cell_fetch <= 1'b0;
            cell_loc   <= '0;
            cell_wdata <= '0;
        end else begin
            cell_store <= want_store;
            cell_fetch <= want_fetch;
            if (want_store || want_fetch) begin
                cell_loc   <= nv_location;
                cell_wdata <= nv_byte;
            end
        end
    end

    // data register: core writes, fetch result overwrites
    always_ff @(posedge clk) begin
        if (srst) begin
            nv_byte_q <= '0;
        end else if (fetch_go && fetch_ack) begin
            nv_byte_q <= fetch_byte;
        end else if (nv_byte_wr) begin
            nv_byte_q <= nv_byte;
        end
    end

    // set wins over clear
    always_ff @(posedge clk) begin
        if (srst) begin
            store_done <= 1'b0;
        end else if (store_go && tif.done) begin
            store_done <= 1'b1;
        end else if (store_done_clr) begin
            store_done <= 1'b0;
        end
    end

    assign nv_access_control = {UPPER_ZERO, store_permit, store_go,
                                fetch_permit, fetch_go};
endmodule : nvbs_ctrl

// >>> design/nvbs_pkg.sv
/*
 nvbs_pkg: constants for the nonvolatile byte store control block.
 Assumes: one 10 MHz clock, synchronous active-high reset.
*/
package nvbs_pkg;
    localparam int          CTRL_W         = 8;
    localparam int          LOC_W          = 7;
    localparam int          BYTE_W         = 8;
    localparam logic [7:0]  CTRL_RESET     = 8'h00;
    localparam int          BIT_FETCH_GO   = 0;
    localparam int          BIT_FETCH_PERM = 1;
    localparam int          BIT_STORE_GO   = 2;
    localparam int          BIT_STORE_PERM = 3;
    localparam logic [3:0]  UPPER_ZERO     = 4'h0;
    localparam int          TICK_W         = 16;
    localparam logic [15:0] STORE_TICKS    = 16'h0020;
    localparam logic [15:0] TICK_ONE       = 16'h0001;
    localparam logic [15:0] TICK_ZERO      = 16'h0000;
    localparam int          TICK_DIV       = 10;
    localparam logic [3:0]  DIV_LAST       = 4'(TICK_DIV - 1);
    localparam logic [3:0]  DIV_ZERO       = 4'h0;
    localparam logic [3:0]  DIV_ONE        = 4'h1;

    typedef enum logic [1:0] {
        NVBS_IDLE  = 2'b00,
        NVBS_STORE = 2'b01,
        NVBS_FETCH = 2'b10
    } nvbs_state_t;
endpackage : nvbs_pkg

// >>> design/nvbs_store_timer.sv
/*
 nvbs_store_timer: counts store-cycle ticks from a clock divider.
 Assumes: start is a one-cycle pulse from the controller.
*/
`timescale 1ns/1ps
module nvbs_store_timer
    import nvbs_pkg::*;
#(
    parameter logic [15:0] TICKS = STORE_TICKS
) (
    // clock and reset
    input  wire logic     clk,
    input  wire logic     srst,
    // controller side
    nvbs_tick_if.timer    tif
);
    logic [3:0]        div;
    logic [TICK_W-1:0] left;
    logic              busy;

    // divider gives one-cycle tick enable
    always_ff @(posedge clk) begin
        if (srst || !busy || div == DIV_LAST) begin
            div <= DIV_ZERO;
        end else begin
            div <= div + DIV_ONE;
        end
    end
    assign tif.tick = busy && (div == DIV_LAST);

    always_ff @(posedge clk) begin
        if (srst) begin
            left <= TICK_ZERO;
            busy <= 1'b0;
        end else if (tif.start) begin
            left <= TICKS;
            busy <= 1'b1;
        end else if (tif.tick) begin
            left <= left - TICK_ONE;
            busy <= (left != TICK_ONE);
        end
    end
    assign tif.done = tif.tick && (left == TICK_ONE);
endmodule : nvbs_store_timer

// >>> design/nvbs_tick_if.sv
/*
 nvbs_tick_if: carries the store timer's start, tick and done signals.
 Assumes: both ends on the same clock.
*/
`timescale 1ns/1ps
interface nvbs_tick_if;
    logic start;
    logic tick;
    logic done;
    modport timer (input start, output tick, output done);
    modport ctrl  (output start, input tick, input done);
endinterface : nvbs_tick_if

// >>> dv/nv_byte_store_control_bench.sv
/* nv_byte_store_control_bench: directed tests of nvbs_ctrl.
   Assumes: bench plays both the core and the cell array. */
`timescale 1ns/1ps
module nv_byte_store_control_bench
    import nvbs_pkg::*;
;
    localparam logic [15:0] LEN = 16'h0002;
    logic       clk = 1'b0, srst = 1'b1, ctrl_wr = 1'b0, nv_byte_wr = 1'b0;
    logic       fetch_ack = 1'b0, store_done_clr = 1'b0;
    logic [7:0] ctrl_wdata = 8'h00, nv_byte = 8'h00, fetch_byte = 8'h00;
    logic [6:0] nv_location = 7'h00, cell_loc;
    logic [7:0] nv_access_control, nv_byte_q, cell_wdata;
    logic       cell_store, cell_fetch, store_done;
    int         bad_count = 0, tests_run = 0, n;
    nvbs_ctrl #(.STORE_LEN(LEN)) dut (.clk, .srst, .ctrl_wr, .ctrl_wdata,
        .nv_access_control, .nv_location, .nv_byte, .nv_byte_wr, .nv_byte_q,
        .cell_store, .cell_fetch, .cell_loc, .cell_wdata, .fetch_ack,
        .fetch_byte, .store_done_clr, .store_done);
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #10;
    endtask : cyc
    task automatic wr(input logic [7:0] d);
        // idle edge first: the strobe never drops and rises in one step
        cyc(1);
        ctrl_wr = 1'b1;
        ctrl_wdata = d;
        cyc(1);
        ctrl_wr = 1'b0;
    endtask : wr
    task automatic results;
        $display("tests_run=%0d bad_count=%0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : results
    initial begin
        forever #50 clk = ~clk;
    end
    initial begin
        #100000;
        bad_count++;
        results();
    end
    initial begin
        cyc(2);
        srst = 1'b0;
        chk(nv_access_control, CTRL_RESET);
        wr(8'hf0);
        chk(nv_access_control, 8'h00);
        wr(8'h04);
        chk({cell_store, nv_access_control[6:0]}, 8'h00);
        wr(8'h01);
        chk({cell_fetch, nv_access_control[6:0]}, 8'h00);
        nv_location = 7'h55;
        nv_byte = 8'ha5;
        wr(8'h08);
        wr(8'h04);
        chk({cell_store, cell_loc}, 8'hd5);
        chk(cell_wdata, 8'ha5);
        wr(8'h08);
        wr(8'h04);
        chk({cell_store, nv_access_control[6:0]}, 8'h04);
        n = 4;
        while (nv_access_control[2] === 1'b1 && n < 400) begin
            cyc(1);
            n++;
        end
        chk({7'h0, n == LEN * TICK_DIV}, 8'h01);
        chk({store_done, nv_access_control[6:0]}, 8'h80);
        cyc(3);
        chk({7'h0, store_done}, 8'h01);
        store_done_clr = 1'b1;
        cyc(1);
        store_done_clr = 1'b0;
        cyc(1);
        chk({7'h0, store_done}, 8'h00);
        wr(8'h02);
        wr(8'h01);
        chk({cell_fetch, nv_access_control[6:0]}, 8'h81);
        cyc(3);
        fetch_ack = 1'b1;
        fetch_byte = 8'h3c;
        cyc(1);
        fetch_ack = 1'b0;
        cyc(1);
        chk(nv_access_control, 8'h00);
        chk(nv_byte_q, 8'h3c);
        nv_byte = 8'h5a;
        nv_byte_wr = 1'b1;
        cyc(1);
        nv_byte_wr = 1'b0;
        chk(nv_byte_q, 8'h5a);
        results();
    end
endmodule : nv_byte_store_control_bench
bind nvbs_ctrl nvbs_ctrl_sva #(.STORE_LEN(STORE_LEN)) u_sva (.clk, .srst,
    .ctrl_wr, .ctrl_wdata, .fetch_ack, .fetch_byte, .nv_access_control,
    .nv_byte_q, .cell_store, .cell_fetch, .store_done);

// >>> dv/nvbs_ctrl_sva.sv
/* nvbs_ctrl_sva: port checks for nvbs_ctrl.
   Assumes: bound to nvbs_ctrl, one clock. */
`timescale 1ns/1ps
module nvbs_ctrl_sva
    import nvbs_pkg::*;
#(
    parameter logic [15:0] STORE_LEN = STORE_TICKS
) (
    input wire logic              clk,
    input wire logic              srst,
    input wire logic              ctrl_wr,
    input wire logic [CTRL_W-1:0] ctrl_wdata,
    input wire logic              fetch_ack,
    input wire logic [BYTE_W-1:0] fetch_byte,
    input wire logic [CTRL_W-1:0] nv_access_control,
    input wire logic [BYTE_W-1:0] nv_byte_q,
    input wire logic              cell_store,
    input wire logic              cell_fetch,
    input wire logic              store_done
);
    logic [CTRL_W-1:0] c;
    logic              wr_idle;
    assign c = nv_access_control;
    assign wr_idle = ctrl_wr && !c[2] && !c[0];
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    a_upper_zero: assert property (c[7:4] == UPPER_ZERO)
        else $error("upper bits set");
    a_store_go: assert property (wr_idle && ctrl_wdata[2] && c[3]
        |=> cell_store && c[2]) else $error("store not launched");
    a_store_refuse: assert property (wr_idle && ctrl_wdata[2] && !c[3]
        |=> !c[2] && !cell_store) else $error("store without permit");
    a_fetch_refuse: assert property (wr_idle && ctrl_wdata[0] && !c[1]
        |=> !c[0] && !cell_fetch) else $error("fetch without permit");
    a_fetch_go: assert property (wr_idle && ctrl_wdata[0] &&
        !ctrl_wdata[2] && c[1] |=> cell_fetch && c[0])
        else $error("fetch not launched");
    a_store_bound: assert property (cell_store |-> c[2][*8] ##[1:400]
        !c[2]) else $error("store length wrong");
    a_done_set: assert property ($fell(c[2]) |-> store_done)
        else $error("store done not set");
    a_fetch_land: assert property (c[0] && fetch_ack |=>
        nv_byte_q == $past(fetch_byte) && !c[0]) else $error("fetch end");
endmodule : nvbs_ctrl_sva
